// *** wwd_pkg.sv ***
/*
 * Shared constants of the window watchdog: state codes, the trigger filter time and the startup reset time.
 * Assumes a 20 MHz reference clock; counts in reference cycles are derived here from times in their own units.
 */
`default_nettype none
package wwd_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned CLK_MHZ = CLK_HZ / 1000000;
	// Shortest low time of a trigger pulse that is accepted.
	localparam int unsigned TRIG_MIN_NS = 7000;
	localparam int unsigned TRIG_MIN_CYCLES = (TRIG_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned TRIG_CNT_W = 8;
	// Reset pulse length after startup, undervoltage or a watchdog fault.
	localparam int unsigned RESET_TIME_US = 4000;
	localparam int unsigned RESET_CYCLES = RESET_TIME_US * CLK_MHZ;
	// Fallback timeouts while the oscillator pin is shorted or open; plain defaults.
	localparam int unsigned FS_SHORT_US = 10000;
	localparam int unsigned FS_OPEN_US = 50000;
	localparam int unsigned FS_SHORT_CYCLES = FS_SHORT_US * CLK_MHZ;
	localparam int unsigned FS_OPEN_CYCLES = FS_OPEN_US * CLK_MHZ;
	localparam int unsigned TMR_W = 24;
	// Window lengths in watchdog oscillator periods.
	localparam int unsigned LEAD_PERIODS = 7895;
	localparam int unsigned CLOSED_PERIODS = 1053;
	localparam int unsigned OPEN_PERIODS = 1105;
	localparam int unsigned PER_W = 16;
	typedef enum logic [1:0] {
		ST_RESET = 2'h0,
		ST_LEAD = 2'h1,
		ST_CLOSED = 2'h3,
		ST_OPEN = 2'h2
	} wwd_state_t;
endpackage
`default_nettype wire

// *** wwd_window_watchdog.sv ***
/*
 * Window watchdog with fail-safe timebase: filters the trigger, times lead, closed and open windows in
 * watchdog oscillator periods and drives the active-low reset output.
 * Assumes all pin inputs are asynchronous to ref_clk_i and that the configuration strobe is on ref_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module wwd_window_watchdog
	import wwd_pkg::*;
#(
	parameter int unsigned RESET_CYC = RESET_CYCLES,
	parameter int unsigned FS_SHORT_CYC = FS_SHORT_CYCLES,
	parameter int unsigned FS_OPEN_CYC = FS_OPEN_CYCLES,
	parameter int unsigned LEAD_PER = LEAD_PERIODS,
	parameter int unsigned CLOSED_PER = CLOSED_PERIODS,
	parameter int unsigned OPEN_PER = OPEN_PERIODS
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Pins from the controller and the analog front end
	input wire logic trigger_in_n_i,
	input wire logic osc_clk_i,
	input wire logic osc_pin_short_i,
	input wire logic osc_pin_open_i,
	input wire logic vcc_uv_i,
	input wire logic strap_disable_i,
	// Configuration words from the serial interface
	input wire logic cfg_wr_i,
	input wire logic cfg_watchdog_disable_bit_i,
	// Reset output and status
	output logic nres_n_o,
	output logic wd_disabled_o
);
	logic [1:0] trig_sync;
	logic trig_d;
	logic [1:0] osc_sync;
	logic osc_d;
	logic [1:0] short_sync;
	logic [1:0] open_sync;
	logic [1:0] uv_sync;
	logic [1:0] strap_sync;
	logic trig_armed;
	logic [TRIG_CNT_W-1:0] low_cnt;
	logic [TRIG_CNT_W-1:0] low_run;
	logic trig_ok;
	logic osc_tick;
	logic fault;
	logic [TMR_W-1:0] fs_limit;
	logic [TMR_W-1:0] tmr;
	logic [PER_W-1:0] per;
	wwd_state_t state;
	wwd_state_t next_state;
	logic restart;
	logic startup;
	logic dis_strap;
	logic dis_cfg;
	logic wdd_pend;
	logic disabled;

	// Every pin passes two flip-flops; only the second stage is read, and trigger and oscillator also keep a delayed copy of it for edge detection.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			trig_sync <= 2'h3;
			osc_sync <= 2'h0;
			short_sync <= 2'h0;
			open_sync <= 2'h0;
			uv_sync <= 2'h0;
			strap_sync <= 2'h0;
			trig_d <= 1'b1;
			osc_d <= 1'b0;
		end else begin
			trig_sync <= {trig_sync[0], trigger_in_n_i};
			osc_sync <= {osc_sync[0], osc_clk_i};
			short_sync <= {short_sync[0], osc_pin_short_i};
			open_sync <= {open_sync[0], osc_pin_open_i};
			uv_sync <= {uv_sync[0], vcc_uv_i};
			strap_sync <= {strap_sync[0], strap_disable_i};
			trig_d <= trig_sync[1];
			osc_d <= osc_sync[1];
		end
	end

	assign osc_tick = osc_sync[1] & ~osc_d;
	assign fault = short_sync[1] | open_sync[1];
	// The two pin faults give the two fallback timeouts.
	assign fs_limit = short_sync[1] ? TMR_W'(FS_SHORT_CYC) : TMR_W'(FS_OPEN_CYC);

	// A falling edge arms the filter; the trigger counts once the line has stayed low long enough.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			trig_armed <= 1'b0;
			low_cnt <= '0;
		end else if (trig_sync[1]) begin
			trig_armed <= 1'b0;
			low_cnt <= '0;
		end else if (trig_d) begin
			trig_armed <= 1'b1;
			low_cnt <= '0;
		end else if (trig_armed) begin
			low_cnt <= low_cnt + TRIG_CNT_W'(1);
			if (trig_ok) begin
				trig_armed <= 1'b0;
			end
		end
	end

	assign trig_ok = trig_armed & ~trig_sync[1] & (low_cnt == TRIG_CNT_W'(TRIG_MIN_CYCLES - 1));

	// The disable bit only takes effect on the second consecutive set write.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			wdd_pend <= 1'b0;
			dis_cfg <= 1'b0;
		end else if (cfg_wr_i) begin
			if (!cfg_watchdog_disable_bit_i) begin
				wdd_pend <= 1'b0;
				dis_cfg <= 1'b0;
			end else if (wdd_pend) begin
				dis_cfg <= 1'b1;
			end else begin
				wdd_pend <= 1'b1;
			end
		end
	end

	// The strap is caught when the startup reset ends, never under reset itself.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			startup <= 1'b1;
			dis_strap <= 1'b0;
		end else if (uv_sync[1]) begin
			startup <= 1'b1;
		end else if (startup && state == ST_RESET && next_state == ST_LEAD) begin
			startup <= 1'b0;
			dis_strap <= strap_sync[1];
		end
	end

	assign disabled = dis_cfg | dis_strap;

	always_comb begin
		next_state = state;
		if (uv_sync[1]) begin
			next_state = ST_RESET;
		end else begin
			unique case (state)
				ST_RESET: begin
					if (tmr == TMR_W'(RESET_CYC - 1)) begin
						next_state = ST_LEAD;
					end
				end
				ST_LEAD: begin
					if (disabled) begin
						next_state = ST_LEAD;
					end else if (fault) begin
						if (tmr == fs_limit - TMR_W'(1)) begin
							next_state = ST_RESET;
						end
					end else if (trig_ok) begin
						next_state = ST_CLOSED;
					end else if (osc_tick && per == PER_W'(LEAD_PER - 1)) begin
						next_state = ST_RESET;
					end
				end
				ST_CLOSED: begin
					if (disabled) begin
						next_state = ST_LEAD;
					end else if (fault) begin
						if (tmr == fs_limit - TMR_W'(1)) begin
							next_state = ST_RESET;
						end
					end else if (trig_ok) begin
						next_state = ST_RESET;
					end else if (osc_tick && per == PER_W'(CLOSED_PER - 1)) begin
						next_state = ST_OPEN;
					end
				end
				ST_OPEN: begin
					if (disabled) begin
						next_state = ST_LEAD;
					end else if (fault) begin
						if (tmr == fs_limit - TMR_W'(1)) begin
							next_state = ST_RESET;
						end
					end else if (trig_ok) begin
						next_state = ST_CLOSED;
					end else if (osc_tick && per == PER_W'(OPEN_PER - 1)) begin
						next_state = ST_RESET;
					end
				end
			endcase
		end
	end

	// A disabled watchdog parks in the lead state with cleared counters, so re-enabling grants a full lead time.
	// Undervoltage holds the timer cleared too, so the reset time always runs from its release.
	assign restart = (next_state != state) | (state == ST_LEAD & disabled) | uv_sync[1];

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state <= ST_RESET;
			nres_n_o <= 1'b0;
		end else begin
			state <= next_state;
			nres_n_o <= (next_state != ST_RESET);
		end
	end

	// The reference-cycle timer is the fallback timebase while the oscillator pin is faulted.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || restart) begin
			tmr <= '0;
		end else begin
			tmr <= tmr + TMR_W'(1);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i || restart) begin
			per <= '0;
		end else if (osc_tick) begin
			per <= per + PER_W'(1);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			wd_disabled_o <= 1'b0;
		end else begin
			wd_disabled_o <= disabled;
		end
	end

	// Separate run length of the synced low level, so the width check does not lean on the filter's own counter.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || trig_sync[1]) begin
			low_run <= '0;
		end else if (low_run != '1) begin
			low_run <= low_run + TRIG_CNT_W'(1);
		end
	end

	sequence s_trig_low_run;
		trig_armed && !trig_sync[1];
	endsequence

	sequence s_reset_entry;
		$rose(state == ST_RESET);
	endsequence

	a_uv_holds_reset: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		uv_sync[1] |=> !nres_n_o)
		else $error("undervoltage did not pull reset low");
	a_closed_trig_resets: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(state == ST_CLOSED && trig_ok && !fault && !disabled) |=> (state == ST_RESET && !nres_n_o))
		else $error("early trigger did not reset");
	a_open_trig_restarts: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(state == ST_OPEN && trig_ok && !fault && !disabled && !uv_sync[1]) |=> (state == ST_CLOSED && per == '0))
		else $error("open window trigger did not restart");
	a_open_expiry: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(state == ST_OPEN && osc_tick && per == PER_W'(OPEN_PER - 1) && !trig_ok && !fault && !disabled)
		|=> !nres_n_o)
		else $error("open window expired without reset");
	a_lead_expiry: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(state == ST_LEAD && osc_tick && per == PER_W'(LEAD_PER - 1) && !trig_ok && !fault && !disabled)
		|=> state == ST_RESET)
		else $error("lead time expired without reset");
	a_reset_length: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(state == ST_RESET && tmr == TMR_W'(RESET_CYC - 1) && !uv_sync[1]) |=> (nres_n_o && $past(!nres_n_o)))
		else $error("reset pulse length wrong");
	a_reset_starts_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_reset_entry |-> tmr == '0)
		else $error("reset timer not cleared on entry");
	a_trig_min_width: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		trig_ok |-> (s_trig_low_run and low_run >= TRIG_CNT_W'(TRIG_MIN_CYCLES)))
		else $error("trigger accepted before minimum width");
	a_single_wdd_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(cfg_wr_i && cfg_watchdog_disable_bit_i && !wdd_pend && !dis_cfg) |=> !dis_cfg)
		else $error("one disable write took effect");
	a_fault_timeout: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(fault && !disabled && state != ST_RESET && tmr == fs_limit - TMR_W'(1)) |=> !nres_n_o)
		else $error("fallback timeout did not reset");
endmodule // wwd_window_watchdog
`default_nettype wire

// *** wwd_host_model.sv ***
/*
 * Host controller model: makes the watchdog oscillator wave and the trigger pulses.
 * Assumes the bench calls pulse() with a low time counted in reference cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module wwd_host_model (
	// Reference clock
	input wire logic ref_clk_i,
	// Pins toward the watchdog
	output logic trigger_in_n_o,
	output logic osc_clk_o
);
	// The half period is unrelated to the reference, so ticks drift against it.
	initial osc_clk_o = 1'b0;
	always #230 osc_clk_o = ~osc_clk_o;
	initial trigger_in_n_o = 1'b1;
	task automatic pulse(input int low_cyc);
		@(posedge ref_clk_i);
		#1 trigger_in_n_o = 1'b0;
		repeat (low_cyc) @(posedge ref_clk_i);
		#1 trigger_in_n_o = 1'b1;
	endtask
endmodule // wwd_host_model
`default_nettype wire

// *** window_watchdog_failsafe_bench.sv ***
/*
 * Self-checking bench of the window watchdog with short window counts.
 * Assumes one oscillator tick is about 9.2 reference cycles, as the host model makes it.
 */
`timescale 1ns/1ps
`default_nettype none
module window_watchdog_failsafe_bench;
	import wwd_pkg::*;
	localparam int RC = 50, FSS = 300, FSO = 500, LD = 60, CL = 30, OP = 40;
	localparam int LDC = LD * 46 / 5;
	localparam int WIN = 142 + (CL + OP) * 46 / 5;
	logic ref_clk_i = 1'b0, rst_i = 1'b1, sh = 1'b0, op = 1'b0, uv = 1'b0, wr = 1'b0, wb = 1'b0, sp = 1'b0;
	logic nres_n_o, wd_disabled_o, saw_low;
	wire logic trig_n, osc;
	int bad_count = 0, check_count = 0, cyc = 0, n;
	always #25 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) if (nres_n_o === 1'b0) saw_low = 1'b1;
	wwd_host_model wwd_host_model_i (.ref_clk_i(ref_clk_i), .trigger_in_n_o(trig_n), .osc_clk_o(osc));
	wwd_window_watchdog #(.RESET_CYC(RC), .FS_SHORT_CYC(FSS), .FS_OPEN_CYC(FSO), .LEAD_PER(LD),
		.CLOSED_PER(CL), .OPEN_PER(OP)) wwd_window_watchdog_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.trigger_in_n_i(trig_n), .osc_clk_i(osc), .osc_pin_short_i(sh), .osc_pin_open_i(op),
		.vcc_uv_i(uv), .strap_disable_i(sp), .cfg_wr_i(wr), .cfg_watchdog_disable_bit_i(wb),
		.nres_n_o(nres_n_o), .wd_disabled_o(wd_disabled_o));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
		end
	endtask
	function automatic logic inr(input int v, input int lo, input int hi);
		return v >= lo && v <= hi;
	endfunction
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask
	// Bounded so a stuck output ends in a failed range check, not a hang.
	task automatic wait_for(input logic v);
		n = 0;
		while (nres_n_o !== v && n < 3000) begin
			step(1);
			n++;
		end
	endtask
	task automatic cfg(input logic b);
		wr = 1'b1;
		wb = b;
		step(1);
		wr = 1'b0;
		step(2);
	endtask
	task automatic train(input int cnt, input int per);
		repeat (cnt) begin
			wwd_host_model_i.pulse(160);
			step(per - 162);
		end
	endtask
	task automatic t_start_and_lead;
		wait_for(1'b1);
		chk("startup", inr(n, RC - 2, RC + 3), 1'b1);
		wwd_host_model_i.pulse(100);
		wait_for(1'b0);
		chk("lead", inr(n + 101, LDC - 15, LDC + 15), 1'b1);
		wait_for(1'b1);
		chk("lead_reset", inr(n, RC - 2, RC + 3), 1'b1);
	endtask
	task automatic t_windows;
		saw_low = 1'b0;
		train(6, 460);
		chk("open_ok", saw_low, 1'b0);
		wait_for(1'b0);
		chk("late", inr(n + 460, WIN - 15, WIN + 15), 1'b1);
		wait_for(1'b1);
		wwd_host_model_i.pulse(160);
		step(39);
		wwd_host_model_i.pulse(160);
		chk("early", nres_n_o, 1'b0);
		wait_for(1'b1);
	endtask
	task automatic t_disable;
		cfg(1'b1);
		cfg(1'b0);
		cfg(1'b1);
		chk("single", wd_disabled_o, 1'b0);
		cfg(1'b1);
		chk("double", wd_disabled_o, 1'b1);
		saw_low = 1'b0;
		step(1500);
		chk("parked", saw_low, 1'b0);
		cfg(1'b0);
		chk("enabled", wd_disabled_o, 1'b0);
		wait_for(1'b0);
		chk("fresh_lead", inr(n, LDC - 15, LDC + 15), 1'b1);
		wait_for(1'b1);
	endtask
	task automatic t_fault;
		sh = 1'b1;
		wait_for(1'b0);
		chk("short", inr(n, FSS - 3, FSS + 5), 1'b1);
		wait_for(1'b1);
		wwd_host_model_i.pulse(160);
		wait_for(1'b0);
		chk("short_again", inr(n + 161, FSS - 3, FSS + 5), 1'b1);
		sh = 1'b0;
		op = 1'b1;
		wait_for(1'b1);
		wait_for(1'b0);
		chk("open", inr(n, FSO - 3, FSO + 5), 1'b1);
		op = 1'b0;
		wait_for(1'b1);
	endtask
	task automatic t_undervoltage;
		uv = 1'b1;
		step(4);
		chk("uv_low", nres_n_o, 1'b0);
		step(100);
		chk("uv_hold", nres_n_o, 1'b0);
		uv = 1'b0;
		wait_for(1'b1);
		chk("uv_release", inr(n, RC - 2, RC + 5), 1'b1);
	endtask
	// The strap is taken at the end of a startup reset and must override a faulted oscillator pin.
	task automatic t_strap;
		sp = 1'b1;
		sh = 1'b1;
		uv = 1'b1;
		step(4);
		uv = 1'b0;
		wait_for(1'b1);
		step(2);
		chk("strap_on", wd_disabled_o, 1'b1);
		saw_low = 1'b0;
		step(700);
		chk("strap_parked", saw_low, 1'b0);
		sp = 1'b0;
		sh = 1'b0;
		uv = 1'b1;
		step(4);
		uv = 1'b0;
		wait_for(1'b1);
		step(2);
		chk("strap_off", wd_disabled_o, 1'b0);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			wrap_up;
		end
	end
	initial begin
		step(5);
		rst_i = 1'b0;
		t_start_and_lead;
		t_windows;
		t_disable;
		t_fault;
		t_undervoltage;
		t_strap;
		wrap_up;
	end
endmodule // window_watchdog_failsafe_bench
`default_nettype wire
